// file: t2co_pkg.sv
// Purpose: Constants for the timer-two clock-out and control block
// Assumes: APB data is 32 bits; each register uses one aligned word
// Notes:   Register indices are multiplied by four to give byte addresses
package t2co_pkg;

	// ----------------------------------------------------------------
	// Register indices, address width and reset value
	// ----------------------------------------------------------------
	localparam int         T2CO_ADDR_W        = 12;
	localparam logic [7:0] T2CO_IDX_CONTROL   = 8'hc8;
	localparam logic [7:0] T2CO_IDX_MODE      = 8'hc9;
	localparam logic [7:0] T2CO_IDX_MODE_ONE  = 8'h93;
	localparam logic [7:0] T2CO_IDX_RELOAD_LO = 8'hca;
	localparam logic [7:0] T2CO_IDX_RELOAD_HI = 8'hcb;
	localparam logic [7:0] T2CO_IDX_COUNT_LO  = 8'hcc;
	localparam logic [7:0] T2CO_IDX_COUNT_HI  = 8'hcd;
	localparam logic [7:0] T2CO_RESET_VAL     = 8'h00;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int C_OVF_FLAG  = 7;
	localparam int C_EXT_FLAG  = 6;
	localparam int C_ALIAS_HI  = 5;
	localparam int C_ALIAS_LO  = 4;
	localparam int C_FALL_EN   = 3;
	localparam int C_RUN       = 2;
	localparam int C_CS0       = 1;
	localparam int C_CAP_SEL   = 0;

	// ----------------------------------------------------------------
	// Mode register fields
	// ----------------------------------------------------------------
	localparam int M_SPLIT     = 7;
	localparam int M_ALIAS     = 6;
	localparam int M_RISE_EN   = 5;
	localparam int M_CS1       = 4;
	localparam int M_LOW_RUN   = 3;
	localparam int M_AUTOCLR   = 2;
	localparam int M_CLKOUT_EN = 1;
	localparam int M_MS0       = 0;

	// ----------------------------------------------------------------
	// Mode-one register fields
	// ----------------------------------------------------------------
	localparam int O_LCS1      = 7;
	localparam int O_OVF_IGN   = 6;
	localparam int O_ALIAS_SEL = 5;
	localparam int O_CS2       = 4;
	localparam int O_MS1       = 3;

	// ----------------------------------------------------------------
	// Timer modes {mode bit 1, capture/reload select, mode bit 0}
	// ----------------------------------------------------------------
	localparam logic [2:0] T2CO_MODE_AR_EXT   = 3'h0;
	localparam logic [2:0] T2CO_MODE_AR_TRIG  = 3'h1;
	localparam logic [2:0] T2CO_MODE_CAPTURE  = 3'h2;
	localparam logic [2:0] T2CO_MODE_CAP_ZERO = 3'h3;
	localparam logic [2:0] T2CO_MODE_DUTY     = 3'h6;

	// ----------------------------------------------------------------
	// Count source codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_DIV12   = 3'h0;
	localparam logic [2:0] SRC_PIN     = 3'h1;
	localparam logic [2:0] SRC_SYSTEM_CLOCK  = 3'h2;
	localparam logic [2:0] SRC_INT0    = 3'h3;
	localparam logic [2:0] SRC_BAUD    = 3'h4;
	localparam logic [2:0] SRC_T0      = 3'h5;
	localparam logic [2:0] SRC_COMP    = 3'h6;
	localparam logic [2:0] SRC_KEYPAD  = 3'h7;
	localparam logic [1:0] LSRC_DIV12  = 2'h0;
	localparam logic [1:0] LSRC_SYSTEM_CLOCK = 2'h1;
	localparam logic [1:0] LSRC_BAUD   = 2'h2;
	localparam logic [1:0] LSRC_INT0   = 2'h3;

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	localparam logic [3:0] T2CO_DIV12_LAST = 4'hb;

endpackage

// file: t2co_timer.sv
// Purpose: Timer two with auto-reload, split mode, clock output and baud ticks
// Assumes: All inputs synchronous to pclk; event inputs are one-cycle pulses
// Notes:   APB slave answers with zero wait states; unmapped addresses error
//
// Summary of operation
// - Capture select 0 and clock-out enable 1 give a 50% square wave.
// - Counter counts selected clock; full overflow reloads both count bytes.
// - Each full or high-byte overflow sets overflow flag outside baud mode; ignore bit blocks its interrupt.
// - Baud ticks and clock output share the same overflow rate.
// - Split mode clock output toggles on low-byte overflow, half its rate.
// - Split mode low counter reloads from low reload byte on overflow.
// - Low overflow sets sticky low flag; requests interrupt when enabled.
// - Overflow flag set by overflow, not while a baud select is set.
// - Enabled trigger edge sets sticky external flag, requests interrupt.
// - Alias select swaps control bits 5,4 and mode bit 6 meanings.
// - Baud select bits route overflow pulses to serial receive/transmit.
// - Trigger edge captures or reloads, unless timer clocks serial port.
// - Run bit starts counter; in split mode low-run bit drives low byte.
// - Three select bits choose the count source of the counter.
// - Two low select bits choose the low counter source in split mode.
// - Split enable makes two 8-bit timers; split with mode 6 halts.
// - Invert bit inverts trigger input before edge detection.
// - Auto-clear drops low-run on high overflow or trigger edge per mode.
// - Clock-out enable gates the clock output pin.
// - Overflow-ignore 1 suppresses overflow interrupt; 0 is default.
`timescale 1ns/100ps

module t2co_timer
	import t2co_pkg::*;
(
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [T2CO_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Count and trigger inputs
	input  wire logic                   count_pin,
	input  wire logic                   trigger_pin,
	input  wire logic                   ext_int_zero_event,
	input  wire logic                   serial_baud_overflow,
	input  wire logic                   timer_zero_overflow,
	input  wire logic                   comparator_event,
	input  wire logic                   keypad_event,
	// Outputs to the system
	output logic                        clock_output_pin,
	output logic                        clock_output_oe,
	output logic                        timer_irq,
	output logic                        rx_baud_tick,
	output logic                        tx_baud_tick,
	output logic                        low_byte_overflow_event
);

	// ----------------------------------------------------------------
	// Register fields
	// ----------------------------------------------------------------
	logic       overflow_flag_reg;
	logic       external_edge_flag_reg;
	logic       rx_baud_select_reg;
	logic       tx_baud_select_reg;
	logic       low_byte_overflow_flag_reg;
	logic       low_byte_irq_enable_reg;
	logic       falling_edge_enable_reg;
	logic       run_control_reg;
	logic       clock_select_bit0_reg;
	logic       capture_reload_select_reg;
	logic       split_enable_reg;
	logic       low_clock_select_bit0_reg;
	logic       trigger_input_invert_reg;
	logic       rising_edge_enable_reg;
	logic       clock_select_bit1_reg;
	logic       low_run_control_reg;
	logic       low_run_autoclear_reg;
	logic       clock_out_enable_reg;
	logic       mode_select_bit0_reg;
	logic       low_clock_select_bit1_reg;
	logic       overflow_irq_ignore_reg;
	logic       alias_select_reg;
	logic       clock_select_bit2_reg;
	logic       mode_select_bit1_reg;
	logic [2:0] capture_source_reg;
	logic [7:0] count_low_byte_reg;
	logic [7:0] count_high_byte_reg;
	logic [7:0] reload_low_byte_reg;
	logic [7:0] reload_high_byte_reg;
	logic       clk_out_reg;
	logic [3:0] presc_reg;
	logic       count_pin_prev_reg;
	logic       trigger_prev_reg;
	logic [31:0] prdata_reg;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic [7:0] idx;
	logic       aligned;
	logic       hit;
	logic       wr;
	logic [7:0] wd;
	logic       wr_ctrl;
	logic       wr_mode;
	logic       wr_mode1;
	logic       wr_rl_lo;
	logic       wr_rl_hi;
	logic       wr_cnt_lo;
	logic       wr_cnt_hi;
	logic [7:0] rd_data;

	assign idx     = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[T2CO_ADDR_W-1:10] == 2'h0);
	assign hit     = aligned && (idx == T2CO_IDX_CONTROL || idx == T2CO_IDX_MODE ||
		idx == T2CO_IDX_MODE_ONE || idx == T2CO_IDX_RELOAD_LO ||
		idx == T2CO_IDX_RELOAD_HI || idx == T2CO_IDX_COUNT_LO ||
		idx == T2CO_IDX_COUNT_HI);
	assign wr        = psel && penable && pwrite && hit;
	assign wd        = pwdata[7:0];
	assign wr_ctrl   = wr && (idx == T2CO_IDX_CONTROL);
	assign wr_mode   = wr && (idx == T2CO_IDX_MODE);
	assign wr_mode1  = wr && (idx == T2CO_IDX_MODE_ONE);
	assign wr_rl_lo  = wr && (idx == T2CO_IDX_RELOAD_LO);
	assign wr_rl_hi  = wr && (idx == T2CO_IDX_RELOAD_HI);
	assign wr_cnt_lo = wr && (idx == T2CO_IDX_COUNT_LO);
	assign wr_cnt_hi = wr && (idx == T2CO_IDX_COUNT_HI);
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !hit;
	assign prdata    = prdata_reg;

	// Alias-dependent views of control bits 5,4 and mode bit 6
	always_comb begin
		rd_data = T2CO_RESET_VAL;
		unique case (idx)
			T2CO_IDX_CONTROL: rd_data = {overflow_flag_reg, external_edge_flag_reg,
				alias_select_reg ? low_byte_overflow_flag_reg : rx_baud_select_reg,
				alias_select_reg ? low_byte_irq_enable_reg : tx_baud_select_reg,
				falling_edge_enable_reg, run_control_reg, clock_select_bit0_reg,
				capture_reload_select_reg};
			T2CO_IDX_MODE: rd_data = {split_enable_reg,
				alias_select_reg ? trigger_input_invert_reg : low_clock_select_bit0_reg,
				rising_edge_enable_reg, clock_select_bit1_reg, low_run_control_reg,
				low_run_autoclear_reg, clock_out_enable_reg, mode_select_bit0_reg};
			T2CO_IDX_MODE_ONE: rd_data = {low_clock_select_bit1_reg, overflow_irq_ignore_reg,
				alias_select_reg, clock_select_bit2_reg, mode_select_bit1_reg,
				capture_source_reg};
			T2CO_IDX_RELOAD_LO: rd_data = reload_low_byte_reg;
			T2CO_IDX_RELOAD_HI: rd_data = reload_high_byte_reg;
			T2CO_IDX_COUNT_LO:  rd_data = count_low_byte_reg;
			T2CO_IDX_COUNT_HI:  rd_data = count_high_byte_reg;
			default:            rd_data = T2CO_RESET_VAL;
		endcase
		if (!aligned) begin
			rd_data = T2CO_RESET_VAL;
		end
	end

	// Read data captured in the setup phase, held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= {24'h00_0000, rd_data};
		end
	end

	// ----------------------------------------------------------------
	// Prescaler and input edges
	// ----------------------------------------------------------------
	logic       div12_tick;
	logic       div2_tick;
	logic       pin_tick;
	logic       trig_now;
	logic       trig_fall;
	logic       trig_rise;
	logic       edge_evt;
	logic       baud_mode;
	logic [2:0] timer_mode;
	logic       halted;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= 4'h0;
		end else if (presc_reg == T2CO_DIV12_LAST) begin
			presc_reg <= 4'h0;
		end else begin
			presc_reg <= presc_reg + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_pin_prev_reg <= 1'b0;
			trigger_prev_reg   <= 1'b0;
		end else begin
			count_pin_prev_reg <= count_pin;
			trigger_prev_reg   <= trig_now;
		end
	end

	assign div12_tick = (presc_reg == T2CO_DIV12_LAST);
	assign div2_tick  = presc_reg[0];
	assign pin_tick   = count_pin_prev_reg && !count_pin;
	assign trig_now   = trigger_pin ^ trigger_input_invert_reg;
	assign trig_fall  = trigger_prev_reg && !trig_now;
	assign trig_rise  = !trigger_prev_reg && trig_now;
	assign edge_evt   = (trig_fall && falling_edge_enable_reg) ||
		(trig_rise && rising_edge_enable_reg);
	assign baud_mode  = rx_baud_select_reg || tx_baud_select_reg;
	assign timer_mode = {mode_select_bit1_reg, capture_reload_select_reg, mode_select_bit0_reg};
	assign halted     = split_enable_reg && (timer_mode == T2CO_MODE_DUTY);

	// ----------------------------------------------------------------
	// Count sources
	// ----------------------------------------------------------------
	logic       src_tick;
	logic       low_tick;
	logic       low_ovf;
	logic       high_ovf;
	logic       full_ovf;
	logic       timer_ovf;
	logic       do_reload;
	logic       do_capture;
	logic       do_zero;

	always_comb begin
		src_tick = 1'b0;
		unique case ({clock_select_bit2_reg, clock_select_bit1_reg, clock_select_bit0_reg})
			SRC_DIV12:  src_tick = baud_mode ? div2_tick : div12_tick;
			SRC_PIN:    src_tick = pin_tick;
			SRC_SYSTEM_CLOCK: src_tick = 1'b1;
			SRC_INT0:   src_tick = split_enable_reg ? low_ovf : ext_int_zero_event;
			SRC_BAUD:   src_tick = serial_baud_overflow;
			SRC_T0:     src_tick = timer_zero_overflow;
			SRC_COMP:   src_tick = comparator_event;
			SRC_KEYPAD: src_tick = keypad_event;
		endcase
	end

	always_comb begin
		low_tick = 1'b0;
		unique case ({low_clock_select_bit1_reg, low_clock_select_bit0_reg})
			LSRC_DIV12:  low_tick = div12_tick;
			LSRC_SYSTEM_CLOCK: low_tick = 1'b1;
			LSRC_BAUD:   low_tick = serial_baud_overflow;
			LSRC_INT0:   low_tick = ext_int_zero_event;
		endcase
	end

	assign low_ovf   = split_enable_reg && !halted && low_run_control_reg && low_tick &&
		(count_low_byte_reg == 8'hff);
	assign high_ovf  = split_enable_reg && !halted && run_control_reg && src_tick &&
		(count_high_byte_reg == 8'hff);
	assign full_ovf  = !split_enable_reg && run_control_reg && src_tick &&
		({count_high_byte_reg, count_low_byte_reg} == 16'hffff);
	assign timer_ovf = full_ovf || high_ovf;

	// Trigger actions; none while the timer clocks the serial port
	assign do_reload  = edge_evt && !baud_mode && (timer_mode == T2CO_MODE_AR_TRIG);
	assign do_capture = edge_evt && !baud_mode && (timer_mode == T2CO_MODE_CAPTURE ||
		timer_mode == T2CO_MODE_CAP_ZERO || timer_mode == T2CO_MODE_DUTY);
	assign do_zero    = do_capture && (timer_mode == T2CO_MODE_CAP_ZERO);

	// ----------------------------------------------------------------
	// Counter bytes
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_low_byte_reg <= T2CO_RESET_VAL;
		end else if (wr_cnt_lo) begin
			count_low_byte_reg <= wd;
		end else if (do_zero) begin
			count_low_byte_reg <= 8'h00;
		end else if (split_enable_reg) begin
			if (low_ovf) begin
				count_low_byte_reg <= reload_low_byte_reg;
			end else if (low_run_control_reg && low_tick && !halted) begin
				count_low_byte_reg <= count_low_byte_reg + 8'h01;
			end
		end else if (full_ovf || do_reload) begin
			count_low_byte_reg <= reload_low_byte_reg;
		end else if (run_control_reg && src_tick) begin
			count_low_byte_reg <= count_low_byte_reg + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_high_byte_reg <= T2CO_RESET_VAL;
		end else if (wr_cnt_hi) begin
			count_high_byte_reg <= wd;
		end else if (do_zero) begin
			count_high_byte_reg <= 8'h00;
		end else if (full_ovf || high_ovf || do_reload) begin
			count_high_byte_reg <= reload_high_byte_reg;
		end else if (run_control_reg && src_tick && !halted) begin
			if (split_enable_reg || count_low_byte_reg == 8'hff) begin
				count_high_byte_reg <= count_high_byte_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_low_byte_reg  <= T2CO_RESET_VAL;
			reload_high_byte_reg <= T2CO_RESET_VAL;
		end else begin
			if (do_capture) begin
				reload_low_byte_reg  <= count_low_byte_reg;
				reload_high_byte_reg <= count_high_byte_reg;
			end
			if (wr_rl_lo) begin
				reload_low_byte_reg <= wd;
			end
			if (wr_rl_hi) begin
				reload_high_byte_reg <= wd;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register; hardware set wins over a software clear
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag_reg          <= 1'b0;
			external_edge_flag_reg     <= 1'b0;
			rx_baud_select_reg         <= 1'b0;
			tx_baud_select_reg         <= 1'b0;
			low_byte_overflow_flag_reg <= 1'b0;
			low_byte_irq_enable_reg    <= 1'b0;
			falling_edge_enable_reg    <= 1'b0;
			run_control_reg            <= 1'b0;
			clock_select_bit0_reg      <= 1'b0;
			capture_reload_select_reg  <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				overflow_flag_reg         <= wd[C_OVF_FLAG];
				external_edge_flag_reg    <= wd[C_EXT_FLAG];
				falling_edge_enable_reg   <= wd[C_FALL_EN];
				run_control_reg           <= wd[C_RUN];
				clock_select_bit0_reg     <= wd[C_CS0];
				capture_reload_select_reg <= wd[C_CAP_SEL];
				if (alias_select_reg) begin
					low_byte_overflow_flag_reg <= wd[C_ALIAS_HI];
					low_byte_irq_enable_reg    <= wd[C_ALIAS_LO];
				end else begin
					rx_baud_select_reg <= wd[C_ALIAS_HI];
					tx_baud_select_reg <= wd[C_ALIAS_LO];
				end
			end
			if (timer_ovf && !baud_mode) begin
				overflow_flag_reg <= 1'b1;
			end
			if (edge_evt) begin
				external_edge_flag_reg <= 1'b1;
			end
			if (low_ovf) begin
				low_byte_overflow_flag_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode and mode-one registers
	// ----------------------------------------------------------------
	logic low_run_clear;

	// Auto-clear on high overflow in modes 0/1, on enabled trigger edge in modes 2/3
	assign low_run_clear = low_run_autoclear_reg &&
		((high_ovf && (timer_mode == T2CO_MODE_AR_EXT || timer_mode == T2CO_MODE_AR_TRIG)) ||
		(edge_evt && (timer_mode == T2CO_MODE_CAPTURE ||
		timer_mode == T2CO_MODE_CAP_ZERO)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			split_enable_reg          <= 1'b0;
			low_clock_select_bit0_reg <= 1'b0;
			trigger_input_invert_reg  <= 1'b0;
			rising_edge_enable_reg    <= 1'b0;
			clock_select_bit1_reg     <= 1'b0;
			low_run_control_reg       <= 1'b0;
			low_run_autoclear_reg     <= 1'b0;
			clock_out_enable_reg      <= 1'b0;
			mode_select_bit0_reg      <= 1'b0;
		end else if (wr_mode) begin
			split_enable_reg       <= wd[M_SPLIT];
			rising_edge_enable_reg <= wd[M_RISE_EN];
			clock_select_bit1_reg  <= wd[M_CS1];
			low_run_control_reg    <= wd[M_LOW_RUN];
			low_run_autoclear_reg  <= wd[M_AUTOCLR];
			clock_out_enable_reg   <= wd[M_CLKOUT_EN];
			mode_select_bit0_reg   <= wd[M_MS0];
			if (alias_select_reg) begin
				trigger_input_invert_reg <= wd[M_ALIAS];
			end else begin
				low_clock_select_bit0_reg <= wd[M_ALIAS];
			end
		end else if (low_run_clear) begin
			low_run_control_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_clock_select_bit1_reg <= 1'b0;
			overflow_irq_ignore_reg   <= 1'b0;
			alias_select_reg          <= 1'b0;
			clock_select_bit2_reg     <= 1'b0;
			mode_select_bit1_reg      <= 1'b0;
			capture_source_reg        <= 3'h0;
		end else if (wr_mode1) begin
			low_clock_select_bit1_reg <= wd[O_LCS1];
			overflow_irq_ignore_reg   <= wd[O_OVF_IGN];
			alias_select_reg          <= wd[O_ALIAS_SEL];
			clock_select_bit2_reg     <= wd[O_CS2];
			mode_select_bit1_reg      <= wd[O_MS1];
			capture_source_reg        <= wd[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Clock output, baud ticks and interrupt request
	// ----------------------------------------------------------------
	logic clk_out_step;

	assign clk_out_step = !capture_reload_select_reg && clock_out_enable_reg &&
		(split_enable_reg ? low_ovf : full_ovf);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_out_reg <= 1'b0;
		end else if (clk_out_step) begin
			clk_out_reg <= !clk_out_reg;
		end
	end

	assign clock_output_pin        = clk_out_reg && clock_out_enable_reg;
	assign clock_output_oe         = clock_out_enable_reg && !capture_reload_select_reg;
	assign rx_baud_tick            = rx_baud_select_reg &&
		(split_enable_reg ? low_ovf : full_ovf);
	assign tx_baud_tick            = tx_baud_select_reg &&
		(split_enable_reg ? low_ovf : full_ovf);
	assign low_byte_overflow_event = low_ovf;
	assign timer_irq = (overflow_flag_reg && !overflow_irq_ignore_reg) ||
		external_edge_flag_reg ||
		(low_byte_overflow_flag_reg && low_byte_irq_enable_reg);

endmodule

// file: t2co_chk.sv
// Purpose: Port-level checker for the timer-two clock-out block
// Assumes: One clock domain, reset asynchronous active low
// Notes:   Bound to t2co_timer below
`timescale 1ns/100ps
module t2co_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Timer outputs
	input wire logic        clock_output_pin,
	input wire logic        clock_output_oe,
	input wire logic        timer_irq,
	input wire logic        rx_baud_tick,
	input wire logic        tx_baud_tick,
	input wire logic        low_byte_overflow_event
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_full_ovf;
		(tx_baud_tick || rx_baud_tick) && clock_output_oe ##1 clock_output_oe;
	endsequence
	sequence s_low_ovf;
		low_byte_overflow_event && clock_output_oe ##1 clock_output_oe;
	endsequence
	sequence s_apb_rd;
		(psel && !penable && !pwrite) ##1 (psel && penable);
	endsequence
	a_full_toggle: assert property (s_full_ovf |-> $changed(clock_output_pin))
		else $error("pin did not toggle on overflow");
	a_split_toggle: assert property (s_low_ovf |-> $changed(clock_output_pin))
		else $error("pin did not toggle on low overflow");
	a_reset_quiet: assert property ($rose(presetn) |-> !clock_output_pin && !timer_irq)
		else $error("outputs not low after reset");
	a_ready_tied: assert property (pready)
		else $error("pready low");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_upper_zero: assert property (prdata[31:8] == 24'h0)
		else $error("prdata upper bits set");
	a_read_stands: assert property (s_apb_rd |=> $stable(prdata))
		else $error("read data moved");
endmodule
bind t2co_timer t2co_chk t2co_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .clock_output_pin, .clock_output_oe, .timer_irq,
	.rx_baud_tick, .tx_baud_tick, .low_byte_overflow_event);

// file: t2co_clk_sink.sv
// Purpose: Receiver of the generated clock; measures high and low times
// Assumes: Pin sampled on pclk
// Notes:   Lengths are in pclk cycles
`timescale 1ns/100ps
module t2co_clk_sink (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Clock from the timer
	input  wire logic        clock_output_pin,
	input  wire logic        clock_output_oe,
	// Measured half periods
	output logic      [15:0] hi_len,
	output logic      [15:0] lo_len
);
	logic [15:0] run;
	logic        last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run    <= 16'h0;
			last   <= 1'b0;
			hi_len <= 16'h0;
			lo_len <= 16'h0;
		end else if (!clock_output_oe) begin
			run  <= 16'h0;
			last <= clock_output_pin;
		end else if (clock_output_pin !== last) begin
			last <= clock_output_pin;
			run  <= 16'h1;
			if (last) hi_len <= run;
			else lo_len <= run;
		end else begin
			run <= run + 16'h1;
		end
	end
endmodule

// file: timer2_clock_out_and_control_bench.sv
// Purpose: Self-checking bench for the timer-two clock-out block
// Assumes: Zero-wait APB slave, system_clock source counts every cycle
// Notes:   Half periods measured by the clock sink
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module timer2_clock_out_and_control_bench;
	import t2co_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, count_pin, trigger_pin;
	logic clock_output_pin, clock_output_oe, timer_irq, rx_baud_tick, tx_baud_tick;
	logic low_byte_overflow_event, se, hit;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] hi_len, lo_len;
	int          err_total, check_count, cyc;
	t2co_timer t2co_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .count_pin, .trigger_pin,
		.ext_int_zero_event(1'b0), .serial_baud_overflow(1'b0), .timer_zero_overflow(1'b0),
		.comparator_event(1'b0), .keypad_event(1'b0), .clock_output_pin, .clock_output_oe,
		.timer_irq, .rx_baud_tick, .tx_baud_tick, .low_byte_overflow_event);
	t2co_clk_sink t2co_clk_sink_inst (.pclk, .presetn, .clock_output_pin, .clock_output_oe,
		.hi_len, .lo_len);
	// ----
	// Bus cycle and reporting
	// ----
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {2'h0, i, 2'h0};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 2000) begin
			err_total++;
			end_sim();
		end
	end
	// ----
	// Tests
	// ----
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		count_pin = 1'b0;
		trigger_pin = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(0, T2CO_IDX_CONTROL, 0);
		`CHK(rd, 32'h0)
		xfer(0, T2CO_IDX_MODE_ONE, 0);
		`CHK(rd, 32'h0)
		xfer(0, 8'h00, 0);
		`CHK(se, 1'b1)
		done("reset and unmapped");
		xfer(1, T2CO_IDX_MODE, 8'h10);
		xfer(1, T2CO_IDX_RELOAD_LO, 8'hfe);
		xfer(1, T2CO_IDX_RELOAD_HI, 8'hff);
		xfer(1, T2CO_IDX_COUNT_LO, 8'hfe);
		xfer(1, T2CO_IDX_COUNT_HI, 8'hff);
		xfer(1, T2CO_IDX_MODE, 8'h12);
		xfer(1, T2CO_IDX_CONTROL, 8'h04);
		repeat (20) @(posedge pclk);
		`CHK(hi_len, 16'h2)
		`CHK(lo_len, 16'h2)
		xfer(0, T2CO_IDX_CONTROL, 0);
		`CHK(rd[7], 1'b1)
		`CHK(timer_irq, 1'b1)
		xfer(1, T2CO_IDX_MODE_ONE, 8'h40);
		xfer(1, T2CO_IDX_CONTROL, 8'h04);
		`CHK(timer_irq, 1'b0)
		done("clock out");
		for (int i = 0; i < 2; i++) begin
			repeat (2) xfer(1, T2CO_IDX_CONTROL, 8'h04 | (8'h10 << i));
			hit = 1'b0;
			repeat (20) begin
				@(posedge pclk);
				if ((i ? rx_baud_tick : tx_baud_tick) === 1'b1) hit = 1'b1;
			end
			`CHK(hit, 1'b1)
			`CHK(hi_len, 16'h2)
			xfer(0, T2CO_IDX_CONTROL, 0);
			`CHK(rd, {24'h0, 8'h04 | (8'h10 << i)})
		end
		done("baud select");
		xfer(1, T2CO_IDX_MODE, 8'h10);
		repeat (3) @(posedge pclk);
		`CHK({clock_output_oe, clock_output_pin}, 2'b00)
		xfer(1, T2CO_IDX_CONTROL, 8'h08);
		trigger_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		xfer(0, T2CO_IDX_CONTROL, 0);
		`CHK(rd, 32'h48)
		`CHK(timer_irq, 1'b1)
		done("disable and trigger");
		xfer(1, T2CO_IDX_MODE_ONE, 8'h00);
		xfer(1, T2CO_IDX_CONTROL, 8'h00);
		xfer(1, T2CO_IDX_MODE, 8'h40);
		xfer(1, T2CO_IDX_RELOAD_LO, 8'hfc);
		xfer(1, T2CO_IDX_COUNT_LO, 8'hfc);
		xfer(1, T2CO_IDX_MODE, 8'hc2);
		xfer(1, T2CO_IDX_MODE, 8'hca);
		repeat (30) @(posedge pclk);
		`CHK(hi_len, 16'h4)
		`CHK(lo_len, 16'h4)
		xfer(1, T2CO_IDX_MODE_ONE, 8'h20);
		xfer(1, T2CO_IDX_CONTROL, 8'h10);
		repeat (8) @(posedge pclk);
		`CHK(timer_irq, 1'b1)
		xfer(1, T2CO_IDX_CONTROL, 8'h00);
		`CHK(timer_irq, 1'b0)
		done("split clock out");
		end_sim();
	end
endmodule
